/* printer_model.sv */
`timescale 1ns/1ns
// Printer stand-in: takes a byte on each strobe fall, then answers busy and accept
module printer_model (
   // Clock
   input wire logic mclk,
   // Lines from the port
   input wire logic strobe_pin,
   input wire logic [7:0] data_pins,
   // Extra answer delay in clocks, set by the bench
   input wire logic [3:0] lag,
   // Handshake lines back to the port
   output logic accept_b,
   output logic not_ready
);
   logic [7:0] rx [$]; // Bytes taken, in order
   int last_w; // Strobe low width of the last byte, in clocks
   int last_d; // Clocks from data change to strobe fall
   int w_cnt; // Running low width
   int d_cnt; // Running clocks since data change
   logic strobe_d; // Strobe seen at the previous edge
   logic [7:0] data_d; // Data seen at the previous edge

   initial begin
      accept_b = 1'b1;
      not_ready = 1'b0;
      strobe_d = 1'b1;
      data_d = 8'h00;
      w_cnt = 0;
      d_cnt = 0;
      last_w = 0;
      last_d = 0;
   end

   // Answer after the strobe ends; busy drops with the end of accept
   task automatic answer();
      not_ready <= 1'b1;
      repeat (lag + 1) @(posedge mclk);
      accept_b <= 1'b0;
      repeat (3) @(posedge mclk);
      accept_b <= 1'b1;
      not_ready <= 1'b0;
   endtask

   // Sample strobe and data on each rising edge
   always @(posedge mclk) begin
      d_cnt = (data_pins != data_d) ? 0 : d_cnt + 1;
      data_d = data_pins;
      if (!strobe_pin) begin
         w_cnt = w_cnt + 1;
      end
      // Byte is taken on the falling strobe
      if (strobe_d && !strobe_pin) begin
         rx.push_back(data_pins);
         last_d = d_cnt;
         w_cnt = 1;
      end
      // Answer only once the strobe is released
      if (!strobe_d && strobe_pin) begin
         last_w = w_cnt;
         fork
            answer();
         join_none
      end
      strobe_d = strobe_pin;
   end
endmodule

/* printer_port_cfg.svh */
`ifndef PRINTER_PORT_CFG_SVH
`define PRINTER_PORT_CFG_SVH
// Register addresses on the two host address lines
`define ADDR_DATA 2'h0
`define ADDR_STATUS 2'h1
`define ADDR_PINS 2'h2
`define ADDR_ALT 2'h3
// Alternate function field positions
`define AF_FIFO_EN 7
`define AF_POL 6
`define AF_TYPE_HI 5
`define AF_TYPE_LO 4
`define AF_SRC 3
// Pin drive field positions
`define PD_STROBE 0
`define PD_LINEFEED 1
`define PD_INIT 2
`define PD_SELECT 3
`define PD_IRQ_EN 4
`define PD_DIR 5
// Reset values
`define PIN_DRIVE_RST 8'h00
`define ALT_RST 8'h00
`define LATCH_RST 8'h00
// Transmit FIFO depth in bytes
`define FIFO_DEPTH 83
// Strobe delay and width in clocks, per timing code
`define TSD_0 5'h06
`define TSD_1 5'h0a
`define TSD_2 5'h0a
`define TSD_3 5'h12
`define TSD_4 5'h03
`define TSD_5 5'h05
`define TSD_6 5'h05
`define TSD_7 5'h09
`define TSW_0 5'h04
`define TSW_1 5'h08
`define TSW_2 5'h08
`define TSW_3 5'h10
`define TSW_4 5'h02
`define TSW_5 5'h04
`define TSW_6 5'h04
`define TSW_7 5'h08
`endif

/* printer_port_fifo_ctrl.sv */
`timescale 1ns/1ns
`include "printer_port_cfg.svh"

// Synchronous byte FIFO with valid/ready on both sides
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clear,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // Fill level
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign in_ready = cnt_ff != CW'(DEPTH);
   assign out_valid = cnt_ff != '0;
   assign out_data = mem[rd_ff];
   assign count = cnt_ff;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer wrap is explicit because depth need not be a power of two
   always_comb begin
      nxt_wr = wr_ff;
      nxt_rd = rd_ff;
      nxt_cnt = cnt_ff;
      if (clear) begin
         nxt_wr = '0;
         nxt_rd = '0;
         nxt_cnt = '0;
      end else begin
         if (push) begin
            nxt_wr = (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
         end
         if (pop) begin
            nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
         end
         nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   // Storage has no reset; out_data shows the entry at the read pointer even when the FIFO is empty
   always_ff @(posedge mclk) begin
      if (push && !clear) begin
         mem[wr_ff] <= in_data;
      end
   end
endmodule

// Behaviour
// - 83-byte FIFO, enabled by alternate bit 7
// - FIFO mode after first strobe and printer answer
// - FIFO mode held until reset, init low or FIFO disable
// - Reset or init change clears FIFO and count
// - Init low: strobe high, data reads pop
// - Plain mode: strobe from drive bit 0
// - FIFO mode: strobe generated, bit 0 ignored
// - Timing code sets strobe delay and width
// - Alternate bit 3 picks accept or not-ready
// - Count up on write, down on pop
// - Write to full FIFO is dropped
// - Latched interrupt cleared by status read
// - Unlatched interrupt: bit 0 lowers, write raises
// - Status bits 6 and 2 show interrupt states
// - Status bit 2 pends on handshake fall
// - Alternate bit 6 inverts interrupt output
// - Alternate bits 5:4 choose interrupt source
// - Status bits 3-5 show fault, online, paper
// - Status bit 7 shows not-full or ready
// - Readback shows real control pin levels and the irq enable bit
// - Drive bits set strobe, feed, reset, select, irq
// - Direction bit picks data pin direction
// - Level register shows count and disable flag
module printer_port_fifo_ctrl (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Host register port
   input wire printer_port_pkg::cpu_bus_t bus,
   input wire logic [7:0] cpu_din,
   output logic [7:0] cpu_dout,
   output logic cpu_dout_oe,
   // Printer data lines
   input wire logic [7:0] printer_data_pins_in,
   output logic [7:0] printer_data_pins_out,
   output logic printer_data_pins_oe,
   // Open-drain handshake outputs
   input wire logic strobe_in,
   output logic strobe_out,
   output logic strobe_oe,
   input wire logic auto_linefeed_in,
   output logic auto_linefeed_out,
   output logic auto_linefeed_oe,
   input wire logic printer_reset_in,
   output logic printer_reset_out,
   output logic printer_reset_oe,
   input wire logic printer_select_in,
   output logic printer_select_out,
   output logic printer_select_oe,
   // Printer status inputs
   input wire printer_port_pkg::prn_status_t prn,
   input wire logic irq_latch_select_pin,
   // Interrupt pin
   output logic irq_out,
   output logic irq_oe
);
   // Host access decode
   logic wr_act_ff, rd_act_ff, wr_ev, rd_ev, rd_now;
   logic wr_data, wr_drive, wr_alt, rd_data, rd_status;
   // Software registers
   logic [7:0] latch_ff, nxt_latch, drive_ff, nxt_drive, alt_ff, nxt_alt;
   // Mode and handshake tracking
   logic fmode_ff, nxt_fmode, strobed_ff, nxt_strobed;
   logic hs_prev_ff, init_prev_ff, hs_cur, hs_fall, init_chg, fmode_enter, fifo_en;
   // Interrupt state
   logic nl_irq_ff, nxt_nl_irq, lat_ff, nxt_lat, src_level;
   // Strobe sequencer
   printer_port_pkg::strobe_state_t st_ff, nxt_st;
   logic [4:0] cnt_ff, nxt_cnt, pulse_lead_delay, pulse_width_clocks;
   // FIFO side
   logic fifo_push, fifo_in_ready, fifo_valid, fifo_pop, fifo_full;
   logic [7:0] fifo_head;
   logic [6:0] fifo_count;
   // Output flops
   logic [7:0] dout_ff, nxt_dout, pd_ff, nxt_pd;
   logic dout_oe_ff, pd_oe_ff, stb_ff, nxt_stb, irq_ff, nxt_irq;
   // Inverted pin copies, kept in flops so no output passes an inverter
   logic [3:0] inv_ff, nxt_inv;

   // Access starts on the first cycle a strobe is seen with chip select
   assign wr_ev = !bus.cs_b && !bus.iow_b && !wr_act_ff;
   assign rd_now = !bus.cs_b && !bus.ior_b;
   assign rd_ev = rd_now && !rd_act_ff;
   assign wr_data = wr_ev && bus.addr == `ADDR_DATA;
   assign wr_drive = wr_ev && bus.addr == `ADDR_PINS;
   assign wr_alt = wr_ev && bus.addr == `ADDR_ALT;
   assign rd_data = rd_ev && bus.addr == `ADDR_DATA;
   assign rd_status = rd_ev && bus.addr == `ADDR_STATUS;

   assign fifo_en = alt_ff[`AF_FIFO_EN];
   // Handshake source select, shared by FIFO pacing and interrupt
   assign hs_cur = alt_ff[`AF_SRC] ? prn.not_ready : prn.accept_b;
   assign hs_fall = hs_prev_ff && !hs_cur;
   assign init_chg = init_prev_ff != printer_reset_in;
   assign fmode_enter = fifo_en && !fmode_ff && strobed_ff && printer_reset_in && hs_fall;
   assign fifo_full = !fifo_in_ready;

   // Strobe timing lookup
   always_comb begin
      case (alt_ff[2:0])
         3'h0: begin pulse_lead_delay = `TSD_0; pulse_width_clocks = `TSW_0; end
         3'h1: begin pulse_lead_delay = `TSD_1; pulse_width_clocks = `TSW_1; end
         3'h2: begin pulse_lead_delay = `TSD_2; pulse_width_clocks = `TSW_2; end
         3'h3: begin pulse_lead_delay = `TSD_3; pulse_width_clocks = `TSW_3; end
         3'h4: begin pulse_lead_delay = `TSD_4; pulse_width_clocks = `TSW_4; end
         3'h5: begin pulse_lead_delay = `TSD_5; pulse_width_clocks = `TSW_5; end
         3'h6: begin pulse_lead_delay = `TSD_6; pulse_width_clocks = `TSW_6; end
         default: begin pulse_lead_delay = `TSD_7; pulse_width_clocks = `TSW_7; end
      endcase
   end

   // Writes reach the FIFO only when enabled; full drops the byte
   assign fifo_push = wr_data && fifo_en;
   // Pops: printer handshake in FIFO mode, first byte on entry, or host read while init is low
   assign fifo_pop = (fmode_ff && st_ff == printer_port_pkg::S_WAIT && hs_fall)
      || fmode_enter
      || (rd_data && fifo_en && !printer_reset_in);

   byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .clear(init_chg),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(cpu_din),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_head),
      .count(fifo_count)
   );

   // Register writes and mode tracking
   always_comb begin
      nxt_latch = wr_data ? cpu_din : latch_ff;
      nxt_drive = wr_drive ? cpu_din : drive_ff;
      nxt_alt = wr_alt ? cpu_din : alt_ff;
      nxt_fmode = fmode_ff || fmode_enter;
      // Leaves FIFO mode only on init low or FIFO disable
      if (!printer_reset_in || !fifo_en) begin
         nxt_fmode = 1'b0;
      end
      nxt_strobed = strobed_ff;
      if (!printer_reset_in || fmode_enter || !fifo_en) begin
         nxt_strobed = 1'b0;
      end else if (!strobe_in) begin
         nxt_strobed = 1'b1;
      end
   end

   // Automatic strobe sequencer; the delay and pulse states each last their count of clocks
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      case (st_ff)
         printer_port_pkg::S_IDLE: begin
            if (fmode_ff && printer_reset_in && fifo_valid) begin
               nxt_st = printer_port_pkg::S_DELAY;
               nxt_cnt = pulse_lead_delay - 5'h01;
            end
         end
         printer_port_pkg::S_DELAY: begin
            if (cnt_ff == 5'h00) begin
               nxt_st = printer_port_pkg::S_PULSE;
               nxt_cnt = pulse_width_clocks - 5'h01;
            end else begin
               nxt_cnt = cnt_ff - 5'h01;
            end
         end
         printer_port_pkg::S_PULSE: begin
            if (cnt_ff == 5'h00) begin
               nxt_st = printer_port_pkg::S_WAIT;
            end else begin
               nxt_cnt = cnt_ff - 5'h01;
            end
         end
         printer_port_pkg::S_WAIT: begin
            if (hs_fall) begin
               nxt_st = printer_port_pkg::S_IDLE;
            end
         end
         default: nxt_st = printer_port_pkg::S_IDLE;
      endcase
      // Abandon the byte if the mode ends mid-sequence
      if (!fmode_ff || !printer_reset_in) begin
         nxt_st = printer_port_pkg::S_IDLE;
      end
   end

   // Interrupt state; pending wins over a status read in the same cycle
   always_comb begin
      nxt_nl_irq = nl_irq_ff;
      if (wr_drive && cpu_din[`PD_STROBE]) begin
         nxt_nl_irq = 1'b0;
      end else if (wr_data) begin
         nxt_nl_irq = 1'b1;
      end
      nxt_lat = lat_ff;
      if (hs_fall || (wr_drive && cpu_din[`PD_STROBE])) begin
         nxt_lat = 1'b0;
      end else if (rd_status) begin
         nxt_lat = 1'b1;
      end
      // Active-low level of the chosen source
      case (alt_ff[`AF_TYPE_HI:`AF_TYPE_LO])
         2'h0: src_level = irq_latch_select_pin ? (nl_irq_ff && prn.accept_b) : lat_ff;
         2'h2: src_level = !fifo_full;
         default: src_level = fifo_valid;
      endcase
      nxt_irq = src_level ^ alt_ff[`AF_POL];
   end

   // Pin drive values
   always_comb begin
      if (!printer_reset_in) begin
         nxt_stb = 1'b1;
      end else if (fmode_ff) begin
         nxt_stb = nxt_st != printer_port_pkg::S_PULSE;
      end else begin
         nxt_stb = !drive_ff[`PD_STROBE];
      end
      nxt_pd = (fifo_en && fifo_valid) ? fifo_head : nxt_latch;
      nxt_inv = {!nxt_stb, !nxt_drive[`PD_LINEFEED], !nxt_drive[`PD_INIT], !nxt_drive[`PD_SELECT]};
   end

   // Read data captured at the start of each read
   always_comb begin
      nxt_dout = dout_ff;
      if (rd_ev) begin
         case (bus.addr)
            `ADDR_DATA: begin
               if (drive_ff[`PD_DIR]) begin
                  nxt_dout = printer_data_pins_in;
               end else if (fifo_en && !printer_reset_in) begin
                  nxt_dout = fifo_head;
               end else begin
                  nxt_dout = latch_ff;
               end
            end
            `ADDR_STATUS: nxt_dout = {
               fifo_en ? !fifo_full : !prn.not_ready,
               alt_ff[`AF_TYPE_HI:`AF_TYPE_LO] == 2'h0 ? (nl_irq_ff && prn.accept_b) : src_level,
               prn.paper_out, prn.printer_online, prn.fault_b,
               lat_ff,
               (alt_ff[`AF_TYPE_HI:`AF_TYPE_LO] == 2'h3) ? 2'h0 : 2'h3};
            `ADDR_PINS: nxt_dout = {3'h7, drive_ff[`PD_IRQ_EN], !printer_select_in, printer_reset_in,
               !auto_linefeed_in, !strobe_in};
            default: nxt_dout = {!fifo_en, fifo_count};
         endcase
      end
   end

   // All state registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_act_ff <= 1'b0;
         rd_act_ff <= 1'b0;
         latch_ff <= `LATCH_RST;
         drive_ff <= `PIN_DRIVE_RST;
         alt_ff <= `ALT_RST;
         fmode_ff <= 1'b0;
         strobed_ff <= 1'b0;
         hs_prev_ff <= 1'b1;
         init_prev_ff <= 1'b0;
         nl_irq_ff <= 1'b1;
         lat_ff <= 1'b1;
         st_ff <= printer_port_pkg::S_IDLE;
         cnt_ff <= 5'h00;
         dout_ff <= 8'h00;
         dout_oe_ff <= 1'b0;
         pd_ff <= `LATCH_RST;
         pd_oe_ff <= 1'b1;
         stb_ff <= 1'b1;
         irq_ff <= 1'b1;
         inv_ff <= 4'h7;
      end else begin
         wr_act_ff <= !bus.cs_b && !bus.iow_b;
         rd_act_ff <= rd_now;
         latch_ff <= nxt_latch;
         drive_ff <= nxt_drive;
         alt_ff <= nxt_alt;
         fmode_ff <= nxt_fmode;
         strobed_ff <= nxt_strobed;
         hs_prev_ff <= hs_cur;
         init_prev_ff <= printer_reset_in;
         nl_irq_ff <= nxt_nl_irq;
         lat_ff <= nxt_lat;
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         dout_ff <= nxt_dout;
         dout_oe_ff <= rd_now;
         pd_ff <= nxt_pd;
         pd_oe_ff <= !nxt_drive[`PD_DIR];
         stb_ff <= nxt_stb;
         irq_ff <= nxt_irq;
         inv_ff <= nxt_inv;
      end
   end

   // Output pins; the four open-drain lines enable only while pulling the line low
   assign cpu_dout = dout_ff;
   assign cpu_dout_oe = dout_oe_ff;
   assign printer_data_pins_out = pd_ff;
   assign printer_data_pins_oe = pd_oe_ff;
   assign strobe_out = stb_ff;
   assign strobe_oe = inv_ff[3];
   assign auto_linefeed_out = inv_ff[2];
   assign auto_linefeed_oe = drive_ff[`PD_LINEFEED];
   assign printer_reset_out = drive_ff[`PD_INIT];
   assign printer_reset_oe = inv_ff[1];
   assign printer_select_out = inv_ff[0];
   assign printer_select_oe = drive_ff[`PD_SELECT];
   assign irq_out = irq_ff;
   assign irq_oe = drive_ff[`PD_IRQ_EN];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   strobe_hold_a: assert property (!printer_reset_in |=> strobe_out)
      else $error("strobe not held high while init low");
   fifo_drop_a: assert property (fifo_push && fifo_full && !fifo_pop && !init_chg |=> $stable(fifo_count))
      else $error("count moved on write to full fifo");
   count_up_a: assert property (fifo_push && !fifo_full && !fifo_pop && !init_chg
      |=> fifo_count == $past(fifo_count) + 7'h01)
      else $error("count did not rise on write");
   init_clear_a: assert property (init_chg |=> fifo_count == 7'h00)
      else $error("fifo not cleared on init change");
   mode_exit_a: assert property (!printer_reset_in |=> !fmode_ff)
      else $error("fifo mode kept with init low");
   lat_pend_a: assert property (hs_fall |=> !lat_ff)
      else $error("latched interrupt not pending after handshake fall");
   status_full_a: assert property (rd_status && fifo_en && fifo_full |=> !cpu_dout[7])
      else $error("status bit 7 not low with full fifo");
   pulse_width_a: assert property ($rose(st_ff == printer_port_pkg::S_PULSE) && alt_ff[2:0] == 3'h4
      && $stable(alt_ff) |-> (st_ff == printer_port_pkg::S_PULSE) [*2] ##1 st_ff != printer_port_pkg::S_PULSE)
      else $error("strobe width wrong for code 4");
   dir_out_a: assert property (wr_drive && !cpu_din[`PD_DIR] |=> printer_data_pins_oe)
      else $error("data pins not driven in output mode");
endmodule

/* printer_port_fifo_ctrl_test.sv */
`timescale 1ns/1ns
module printer_port_fifo_ctrl_test;
   // Clock and reset
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   // Host side
   printer_port_pkg::cpu_bus_t bus = '{cs_b: 1'b1, ior_b: 1'b1, iow_b: 1'b1, addr: 2'h0};
   logic [7:0] cpu_din = 8'h00;
   logic [7:0] cpu_dout;
   logic cpu_dout_oe;
   // Printer side wires
   logic [7:0] pd_out, pd_in;
   logic [7:0] tb_pins = 8'h00; // Far side drive in input mode
   logic pd_oe, stb_out, stb_oe, lf_out, lf_oe, rs_out, rs_oe, sel_out, sel_oe;
   logic stb_pin, lf_pin, rs_pin, sel_pin;
   logic fault_b = 1'b1;
   logic online = 1'b1;
   logic paper = 1'b0;
   logic isel = 1'b0;
   logic accept_b, not_ready, irq_out, irq_oe;
   logic [3:0] lag = 4'h0;
   printer_port_pkg::prn_status_t prn;
   int fails = 0;
   int cmp_count = 0;
   logic [7:0] rv;
   logic rd_oe; // Read bus enable seen while the read strobe stands
   int n0;
   // Strobe delay and width per timing code
   logic [7:0] pulse_lead_delay [8] = '{8'h06, 8'h0a, 8'h0a, 8'h12, 8'h03, 8'h05, 8'h05, 8'h09};
   logic [7:0] pulse_width_clocks [8] = '{8'h04, 8'h08, 8'h08, 8'h10, 8'h02, 8'h04, 8'h04, 8'h08};

   // Open-drain lines are pulled high when nobody pulls them
   assign stb_pin = stb_oe ? stb_out : 1'b1;
   assign lf_pin = lf_oe ? lf_out : 1'b1;
   assign rs_pin = rs_oe ? rs_out : 1'b1;
   assign sel_pin = sel_oe ? sel_out : 1'b1;
   assign pd_in = pd_oe ? pd_out : tb_pins;
   assign prn = '{fault_b: fault_b, printer_online: online, paper_out: paper, accept_b: accept_b,
      not_ready: not_ready};

   always #10 mclk = ~mclk;

   printer_port_fifo_ctrl dut (
      .mclk(mclk), .rst_b(rst_b), .bus(bus), .cpu_din(cpu_din), .cpu_dout(cpu_dout),
      .cpu_dout_oe(cpu_dout_oe), .printer_data_pins_in(pd_in), .printer_data_pins_out(pd_out),
      .printer_data_pins_oe(pd_oe), .strobe_in(stb_pin), .strobe_out(stb_out), .strobe_oe(stb_oe),
      .auto_linefeed_in(lf_pin), .auto_linefeed_out(lf_out), .auto_linefeed_oe(lf_oe),
      .printer_reset_in(rs_pin), .printer_reset_out(rs_out), .printer_reset_oe(rs_oe),
      .printer_select_in(sel_pin), .printer_select_out(sel_out), .printer_select_oe(sel_oe),
      .prn(prn), .irq_latch_select_pin(isel), .irq_out(irq_out), .irq_oe(irq_oe)
   );

   printer_model pm (
      .mclk(mclk), .strobe_pin(stb_pin), .data_pins(pd_in), .lag(lag),
      .accept_b(accept_b), .not_ready(not_ready)
   );

   // Byte compare, counted
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One register write; strobe released for one edge after
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      bus.addr = a;
      cpu_din = d;
      bus.cs_b = 1'b0;
      bus.iow_b = 1'b0;
      @(negedge mclk);
      bus.cs_b = 1'b1;
      bus.iow_b = 1'b1;
      @(negedge mclk);
   endtask

   // One register read; data is settled one edge after the start
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      bus.addr = a;
      bus.cs_b = 1'b0;
      bus.ior_b = 1'b0;
      @(negedge mclk);
      d = cpu_dout;
      rd_oe = cpu_dout_oe;
      bus.cs_b = 1'b1;
      bus.ior_b = 1'b1;
      @(negedge mclk);
   endtask

   // Wait for the printer to take bytes, then for its answer to end
   task automatic wait_rx(input int n);
      int k;
      k = 0;
      while (pm.rx.size() < n && k < 400) begin
         @(negedge mclk);
         k++;
      end
      repeat (40) @(negedge mclk);
   endtask

   // Counts, then the verdict
   task automatic give_verdict();
      $display("Counts: %0d compared, %0d failed", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Cut a hang short; the whole run is well under two thousand clocks
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      $display("Error %0t: watchdog expired", $time);
      give_verdict();
   end

   // Main sequence
   initial begin
      repeat (2) @(negedge mclk);
      rst_b = 1'b1;
      @(negedge mclk);
      rd(2'h2, rv); chk("readback", rv, 8'he0);
      chk("read enable", {7'h00, rd_oe}, 8'h01);
      rd(2'h3, rv); chk("level", rv, 8'h80);
      rd(2'h1, rv); chk("status", rv, 8'hdf);
      $display("Test reset state done");
      // Pin drive and readback
      wr(2'h2, 8'h1e);
      chk("pins", {5'h00, sel_pin, rs_pin, lf_pin}, 8'h02);
      rd(2'h2, rv); chk("readback", rv, 8'hfe);
      wr(2'h2, 8'h14);
      rd(2'h2, rv); chk("readback", rv, 8'hf4);
      chk("irq enable", {7'h00, irq_oe}, 8'h01);
      $display("Test pin drive done");
      // Data direction
      wr(2'h0, 8'h5a);
      chk("pins out", pd_in, 8'h5a);
      wr(2'h2, 8'h34);
      tb_pins = 8'ha3;
      rd(2'h0, rv); chk("pins in", rv, 8'ha3);
      wr(2'h2, 8'h14);
      $display("Test direction done");
      // Latched interrupt; the hand strobe reaches the printer
      wr(2'h2, 8'h15);
      chk("irq set", {7'h00, irq_out}, 8'h00);
      wr(2'h2, 8'h14);
      wait_rx(1);
      chk("taken", pm.rx[0], 8'h5a);
      rd(2'h1, rv); chk("pending", rv & 8'h04, 8'h00);
      rd(2'h1, rv); chk("cleared", rv & 8'h04, 8'h04);
      chk("irq clr", {7'h00, irq_out}, 8'h01);
      $display("Test latched interrupt done");
      // Unlatched interrupt and polarity
      isel = 1'b1;
      wr(2'h2, 8'h15);
      chk("irq low", {7'h00, irq_out}, 8'h00);
      wr(2'h2, 8'h14);
      wait_rx(2);
      chk("irq held", {7'h00, irq_out}, 8'h00);
      wr(2'h0, 8'h66);
      chk("irq high", {7'h00, irq_out}, 8'h01);
      rd(2'h1, rv); chk("level bit", rv & 8'h40, 8'h40);
      wr(2'h3, 8'h40);
      chk("irq inv", {7'h00, irq_out}, 8'h00);
      $display("Test unlatched interrupt done");
      // Interrupt sources with an empty, not full FIFO
      for (int c = 1; c < 4; c++) begin
         wr(2'h3, {2'b00, c[1:0], 4'h0});
         rd(2'h1, rv); chk("src bits", rv & 8'h03, (c == 3) ? 8'h00 : 8'h03);
         chk("src irq", {7'h00, irq_out}, (c == 2) ? 8'h01 : 8'h00);
      end
      $display("Test interrupt source done");
      // Status inputs, all eight patterns
      for (int i = 0; i < 8; i++) begin
         {fault_b, online, paper} = i[2:0];
         rd(2'h1, rv); chk("inputs", rv & 8'hb8, {2'b10, paper, online, fault_b, 3'b000});
      end
      {fault_b, online, paper} = 3'b110;
      $display("Test status inputs done");
      // Init low: reads pop, strobe stays high
      wr(2'h3, 8'h80);
      wr(2'h2, 8'h10);
      wr(2'h0, 8'h11);
      wr(2'h0, 8'h22);
      wr(2'h2, 8'h11);
      chk("strobe held", {7'h00, stb_pin}, 8'h01);
      rd(2'h3, rv); chk("level", rv, 8'h02);
      rd(2'h0, rv); chk("pop", rv, 8'h11);
      rd(2'h0, rv); chk("pop", rv, 8'h22);
      rd(2'h3, rv); chk("level", rv, 8'h00);
      $display("Test init low done");
      // Fill past full, then clear by init change
      wr(2'h2, 8'h14);
      for (int i = 0; i < 84; i++) wr(2'h0, i[7:0]);
      rd(2'h3, rv); chk("full level", rv, 8'h53);
      rd(2'h1, rv); chk("full flag", rv & 8'h80, 8'h00);
      wr(2'h2, 8'h10);
      rd(2'h3, rv); chk("cleared", rv, 8'h00);
      $display("Test full FIFO done");
      // Streaming for every timing code, both handshake sources
      for (int c = 0; c < 8; c++) begin
         lag = c[3:0];
         wr(2'h2, 8'h10);
         wr(2'h2, 8'h14);
         wr(2'h3, {4'h8, c[0], c[2:0]});
         n0 = pm.rx.size();
         for (int b = 0; b < 3; b++) wr(2'h0, {c[3:0], 2'b01, b[1:0]});
         rd(2'h3, rv); chk("queued", rv, 8'h03);
         wr(2'h2, 8'h15);
         wr(2'h2, 8'h14);
         wait_rx(n0 + 3);
         for (int b = 0; b < 3; b++) chk("order", pm.rx[n0 + b], {c[3:0], 2'b01, b[1:0]});
         chk("width", pm.last_w[7:0], pulse_width_clocks[c]);
         chk("delay", {7'h00, pm.last_d >= pulse_lead_delay[c] && pm.last_d <= pulse_lead_delay[c] + 3}, 8'h01);
         rd(2'h3, rv); chk("drained", rv, 8'h00);
         wr(2'h2, 8'h15);
         chk("bit0 ignored", {7'h00, stb_pin}, 8'h01);
      end
      $display("Test streaming done");
      give_verdict();
   end
endmodule

/* printer_port_pkg.sv */
package printer_port_pkg;
   // Host bus strobes and address
   typedef struct packed {
      logic cs_b;
      logic ior_b;
      logic iow_b;
      logic [1:0] addr;
   } cpu_bus_t;
   // Printer status lines, raw pin levels
   typedef struct packed {
      logic fault_b;
      logic printer_online;
      logic paper_out;
      logic accept_b;
      logic not_ready;
   } prn_status_t;
   // Automatic strobe sequencer
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_DELAY = 2'b01,
      S_PULSE = 2'b10,
      S_WAIT = 2'b11
   } strobe_state_t;
endpackage
